/* File: t1ac_ctrl.sv */
// Remote alarm, AIS selection and transmit boundary control with APB.
//
// Notes on behaviour
// - Format 00 sends no remote alarm.
// - SF/N format 01: bit 2 zero everywhere.
// - Data mode framing: Y-bit driven to zero.
// - ESF 01: 255 patterns eight ones, eight zeros.
// - Short enable still yields exactly 255 patterns.
// - Long enable keeps alarm until cleared.
// - New enable pulse restarts the pattern count.
// - One second idle between successive alarms.
// - SF format 10: Fs one in frame 12.
// - ESF format 11: patterns of sixteen ones.
// - SF/N/data mode: 11 acts as 01.
// - AIS select 00/10 sends normal traffic.
// - AIS select 01 sends unframed all ones.
// - AIS select 11 sends framed all ones.
// - Detect criteria 00/10 never declares AIS.
// - Criteria 01 accepts unframed or framed AIS.
// - Criteria 11 accepts framed AIS only.
// - Multiframe align only outside base rate.
// - High rate: frame pin may mark superframe.
// - Base rate: multiframe pin marks superframes.
// - Serial clock source plus select 1: inputs.
// - Sampled high boundary input starts frame.
// - Enable ignored unless one-second rule set.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module t1ac_ctrl
  import t1ac_pkg::*;
#(
  parameter int unsigned GUARD_CYCLES = T1AC_GUARD_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Framer timing from the same clock domain
  input  wire logic        dl_slot_i,
  input  wire logic        int_frame_i,
  input  wire logic        int_mframe_i,
  // Transmit backplane pins
  input  wire logic        tx_serial_clock_i,
  input  wire logic        tx_frame_boundary_i,
  output logic             tx_frame_boundary_o,
  output logic             tx_frame_boundary_oe_o,
  input  wire logic        tx_multiframe_boundary_i,
  output logic             tx_multiframe_boundary_o,
  output logic             tx_multiframe_boundary_oe_o,
  // Frame start requests to the transmit framer
  output logic             tx_frame_start_o,
  output logic             tx_mframe_start_o,
  // Remote alarm controls
  output logic             rai_active_o,
  output logic             rai_bit2_zero_o,
  output logic             rai_ybit_zero_o,
  output logic             rai_fs12_one_o,
  output logic             dl_override_o,
  output logic             dl_bit_o,
  // AIS controls
  output logic             tx_ais_unframed_o,
  output logic             tx_ais_framed_o,
  output logic             rx_ais_unframed_en_o,
  output logic             rx_ais_framed_en_o
);

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [7:0]  agr_q;
  logic [7:0]  smr_q;
  logic [1:0]  css_q;
  logic [2:0]  mode_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  wire setup_ph   = psel & ~penable;
  wire wr_en      = psel & penable & pready_q & pwrite;
  wire hit_css    = (paddr == T1AC_CSS_ADDR);
  wire hit_agr    = (paddr == T1AC_AGR_ADDR);
  wire hit_smr    = (paddr == T1AC_SMR_ADDR);
  wire hit_mode   = (paddr == T1AC_MODE_ADDR);
  wire hit_stat   = (paddr == T1AC_STAT_ADDR);
  wire hit_any    = hit_css | hit_agr | hit_smr | hit_mode | hit_stat;
  wire bad_write  = hit_stat & pwrite;

  wire       one_sec   = agr_q[T1AC_AGR_ONESEC];
  wire       enb_bit   = agr_q[T1AC_AGR_ENB];
  wire [1:0] yel       = agr_q[T1AC_AGR_YEL +: 2];
  wire [1:0] aisg      = agr_q[T1AC_AGR_AISG +: 2];
  wire [1:0] aisd      = agr_q[T1AC_AGR_AISD +: 2];
  wire       mfa       = smr_q[T1AC_SMR_MFA];
  wire       frame_sync_as_superframe     = smr_q[T1AC_SMR_FRAME_SYNC_AS_SUPERFRAME];
  wire       fss       = smr_q[T1AC_SMR_FSS];
  wire       high_rate = mode_q[T1AC_MODE_HR];
  wire [1:0] framing   = mode_q[1:0];

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      agr_q  <= T1AC_AGR_RST;
      smr_q  <= T1AC_SMR_RST;
      css_q  <= T1AC_CSS_RST;
      mode_q <= T1AC_MODE_RST;
    end else if (wr_en) begin
      if (hit_agr)  agr_q  <= pwdata[7:0];
      if (hit_smr)  smr_q  <= pwdata[7:0] & T1AC_SMR_MASK;
      if (hit_css)  css_q  <= pwdata[1:0];
      if (hit_mode) mode_q <= pwdata[2:0];
    end
  end

  // ---------------------------------------------------------------------
  // Alarm sequencer
  // ---------------------------------------------------------------------
  t1ac_state_t state_q;
  t1ac_state_t state_d;
  logic [7:0]  pat_cnt_q;
  logic [3:0]  bit_cnt_q;
  logic [31:0] guard_cnt_q;
  logic        en_prev_q;
  logic        pend_q;

  wire en_eff   = one_sec & enb_bit;
  wire en_rise  = en_eff & ~en_prev_q;
  wire yel_on   = (yel != T1AC_SEL_00);
  wire pat_done = (pat_cnt_q == T1AC_PAT_COUNT);
  wire pat_end  = dl_slot_i & (bit_cnt_q == T1AC_PAT_LAST);
  wire guard_0  = (guard_cnt_q == 32'h0);
  wire sending  = (state_q == T1AC_ST_SEND);
  wire restart  = sending & en_rise & yel_on;

  always_comb begin
    state_d = state_q;
    case (state_q)
      T1AC_ST_IDLE: begin
        if (en_rise && yel_on) state_d = T1AC_ST_SEND;
      end
      T1AC_ST_SEND: begin
        if (!yel_on || (pat_done && !en_eff)) state_d = T1AC_ST_GUARD;
      end
      T1AC_ST_GUARD: begin
        if (guard_0) state_d = (pend_q && yel_on) ? T1AC_ST_SEND
                                                  : T1AC_ST_IDLE;
      end
      default: state_d = T1AC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q   <= T1AC_ST_IDLE;
      en_prev_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      en_prev_q <= en_eff;
    end
  end

  // Pattern counters run only while sending; the pattern count stops at the last pattern while the bit count wraps.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pat_cnt_q <= 8'h00;
      bit_cnt_q <= 4'h0;
    end else if (!sending || restart) begin
      pat_cnt_q <= 8'h00;
      bit_cnt_q <= 4'h0;
    end else if (dl_slot_i) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (pat_end && !pat_done) pat_cnt_q <= pat_cnt_q + 8'h01;
    end
  end

  // A request that arrives during the idle gap is held until it ends, and dropped if the enable falls first.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      guard_cnt_q <= 32'h0;
      pend_q      <= 1'b0;
    end else begin
      if (sending && state_d == T1AC_ST_GUARD)
        guard_cnt_q <= GUARD_CYCLES - 32'd1;
      else if (!guard_0)
        guard_cnt_q <= guard_cnt_q - 32'h1;
      if (state_q == T1AC_ST_GUARD && en_rise)
        pend_q <= 1'b1;
      else if (state_q != T1AC_ST_GUARD || !en_eff)
        pend_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Alarm and AIS outputs
  // ---------------------------------------------------------------------
  wire is_esf   = (framing == T1AC_FR_ESF);
  wire is_sf    = (framing == T1AC_FR_SF);
  wire is_n     = (framing == T1AC_FR_N);
  wire is_dm    = (framing == T1AC_FR_DM);
  wire fmt_0111 = (yel == T1AC_SEL_01) | (yel == T1AC_SEL_11);
  wire act      = sending & yel_on;
  wire bit2_d   = act & (is_sf | is_n) & fmt_0111;
  wire ybit_d   = act & is_dm;
  wire fs12_d   = act & is_sf & (yel == T1AC_SEL_10);
  wire dlov_d   = act & is_esf & fmt_0111;
  wire ones16   = (yel == T1AC_SEL_11);
  wire pbit     = ones16 | (bit_cnt_q < T1AC_PAT_HALF);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rai_active_o         <= 1'b0;
      rai_bit2_zero_o      <= 1'b0;
      rai_ybit_zero_o      <= 1'b0;
      rai_fs12_one_o       <= 1'b0;
      dl_override_o        <= 1'b0;
      dl_bit_o             <= 1'b0;
      tx_ais_unframed_o    <= 1'b0;
      tx_ais_framed_o      <= 1'b0;
      rx_ais_unframed_en_o <= 1'b0;
      rx_ais_framed_en_o   <= 1'b0;
    end else begin
      rai_active_o         <= act;
      rai_bit2_zero_o      <= bit2_d;
      rai_ybit_zero_o      <= ybit_d;
      rai_fs12_one_o       <= fs12_d;
      dl_override_o        <= dlov_d;
      if (dl_slot_i) dl_bit_o <= dlov_d & pbit;
      tx_ais_unframed_o    <= (aisg == T1AC_SEL_01);
      tx_ais_framed_o      <= (aisg == T1AC_SEL_11);
      rx_ais_unframed_en_o <= (aisd == T1AC_SEL_01);
      rx_ais_framed_en_o   <= aisd[0];
    end
  end

  // ---------------------------------------------------------------------
  // Transmit boundary pins
  // ---------------------------------------------------------------------
  logic [2:0] pin_s;
  logic       sclk_prev_q;

  t1ac_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i ({tx_serial_clock_i, tx_multiframe_boundary_i,
               tx_frame_boundary_i}),
    .sync_o  (pin_s)
  );

  wire sclk_rise  = pin_s[2] & ~sclk_prev_q;
  wire sys_ctrl   = (css_q == T1AC_CSS_TXCLK) & fss;
  wire fr_oe_d    = ~sys_ctrl;
  wire mf_oe_d    = ~sys_ctrl & ~high_rate;
  wire fr_hit     = sys_ctrl & sclk_rise & pin_s[0];
  wire mf_hit     = sys_ctrl & sclk_rise & pin_s[1] & ~high_rate;
  wire hr_super   = high_rate & frame_sync_as_superframe;
  wire fstart_d   = fr_hit & ~(hr_super & mfa);
  wire mstart_d   = mf_hit | (fr_hit & hr_super & mfa);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sclk_prev_q                 <= 1'b0;
      tx_frame_boundary_o         <= 1'b0;
      tx_frame_boundary_oe_o      <= 1'b0;
      tx_multiframe_boundary_o    <= 1'b0;
      tx_multiframe_boundary_oe_o <= 1'b0;
      tx_frame_start_o            <= 1'b0;
      tx_mframe_start_o           <= 1'b0;
    end else begin
      sclk_prev_q                 <= pin_s[2];
      tx_frame_boundary_o         <= fr_oe_d & int_frame_i;
      tx_frame_boundary_oe_o      <= fr_oe_d;
      tx_multiframe_boundary_o    <= mf_oe_d & int_mframe_i;
      tx_multiframe_boundary_oe_o <= mf_oe_d;
      tx_frame_start_o            <= fstart_d;
      tx_mframe_start_o           <= mstart_d;
    end
  end

  // ---------------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------------
  wire [31:0] stat_w = {16'h0000, pat_cnt_q, 5'h00, pend_q,
                        (state_q == T1AC_ST_GUARD), act};
  wire [31:0] rd_mux = hit_agr  ? {24'h000000, agr_q}   :
                       hit_smr  ? {24'h000000, smr_q}   :
                       hit_css  ? {30'h00000000, css_q} :
                       hit_mode ? {29'h00000000, mode_q} :
                       hit_stat ? stat_w : 32'h00000000;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & (~hit_any | bad_write);
      if (setup_ph) prdata_q <= pwrite ? 32'h00000000 : rd_mux;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  yel_off_a: assert property (yel == T1AC_SEL_00 |=> !rai_active_o
    && !rai_bit2_zero_o && !dl_override_o)
    else $error("Remote alarm sent with format 00.");
  bit2_zero_a: assert property (act && is_sf && yel == T1AC_SEL_01
    |=> rai_bit2_zero_o && !rai_fs12_one_o)
    else $error("Bit 2 alarm not driven in SF format 01.");
  ybit_zero_a: assert property (act && is_dm |=> rai_ybit_zero_o)
    else $error("Y-bit alarm not driven in data mode.");
  fs12_one_a: assert property (act && is_sf && yel == T1AC_SEL_10
    |=> rai_fs12_one_o && !rai_bit2_zero_o)
    else $error("Fs bit alarm wrong for format 10.");
  pat_count_a: assert property (sending && pat_end && !pat_done
    && !restart |=> pat_cnt_q == $past(pat_cnt_q) + 8'h01)
    else $error("Pattern counter did not advance.");
  short_stop_a: assert property (sending && pat_done && !en_eff
    |=> state_q == T1AC_ST_GUARD)
    else $error("Alarm did not end after 255 patterns.");
  long_hold_a: assert property (sending && yel_on && en_eff
    |=> sending)
    else $error("Alarm ended while enable high.");
  restart_cnt_a: assert property (restart |=> pat_cnt_q == 8'h00
    && bit_cnt_q == 4'h0)
    else $error("Enable pulse did not restart pattern count.");
  guard_load_a: assert property ($rose(state_q == T1AC_ST_GUARD)
    |-> guard_cnt_q == GUARD_CYCLES - 32'd1)
    else $error("Idle gap loaded with wrong length.");
  guard_hold_a: assert property (state_q == T1AC_ST_GUARD && !guard_0
    |=> state_q == T1AC_ST_GUARD)
    else $error("Idle gap cut short.");
  esf_ones_a: assert property (dl_slot_i && dlov_d && ones16
    |=> dl_bit_o)
    else $error("ESF format 11 pattern not all ones.");
  ais_tx_a: assert property (aisg[0] == 1'b0 |=> !tx_ais_unframed_o
    && !tx_ais_framed_o)
    else $error("AIS sent while disabled.");
  ais_rx_a: assert property (aisd == T1AC_SEL_11
    |=> rx_ais_framed_en_o
    && !rx_ais_unframed_en_o)
    else $error("Framed-only AIS criteria wrong.");
  no_rule_a: assert property (!one_sec && state_q == T1AC_ST_IDLE
    |=> state_q == T1AC_ST_IDLE)
    else $error("Alarm started without one-second rule.");
  pin_dir_a: assert property (sys_ctrl |=> !tx_frame_boundary_oe_o
    && !tx_multiframe_boundary_oe_o)
    else $error("Boundary pins driven under system control.");

  alarm_cycle_c: cover property (sending ##1 state_q == T1AC_ST_GUARD);
  restart_c:     cover property (restart);
  frame_in_c:    cover property (tx_frame_start_o);

endmodule

/* File: t1ac_pkg.sv */
// Constants shared by the alarm and transmit sync control block.
package t1ac_pkg;

  // ---------------------------------------------------------------------
  // Register indices and byte addresses
  // ---------------------------------------------------------------------
  localparam logic [11:0] T1AC_CSS_IDX    = 12'h100;
  localparam logic [11:0] T1AC_AGR_IDX    = 12'h108;
  localparam logic [11:0] T1AC_SMR_IDX    = 12'h109;
  localparam logic [11:0] T1AC_MODE_IDX   = 12'h10a;
  localparam logic [11:0] T1AC_STAT_IDX   = 12'h10b;
  localparam logic [13:0] T1AC_CSS_ADDR   = {T1AC_CSS_IDX, 2'b00};
  localparam logic [13:0] T1AC_AGR_ADDR   = {T1AC_AGR_IDX, 2'b00};
  localparam logic [13:0] T1AC_SMR_ADDR   = {T1AC_SMR_IDX, 2'b00};
  localparam logic [13:0] T1AC_MODE_ADDR  = {T1AC_MODE_IDX, 2'b00};
  localparam logic [13:0] T1AC_STAT_ADDR  = {T1AC_STAT_IDX, 2'b00};

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned T1AC_AGR_ONESEC = 7;
  localparam int unsigned T1AC_AGR_ENB    = 6;
  localparam int unsigned T1AC_AGR_YEL    = 4;
  localparam int unsigned T1AC_AGR_AISG   = 2;
  localparam int unsigned T1AC_AGR_AISD   = 0;
  localparam int unsigned T1AC_SMR_MFA    = 6;
  localparam int unsigned T1AC_SMR_FRAME_SYNC_AS_SUPERFRAME  = 5;
  localparam int unsigned T1AC_SMR_FSS    = 4;
  localparam int unsigned T1AC_MODE_HR    = 2;
  localparam logic [7:0]  T1AC_AGR_RST    = 8'h00;
  localparam logic [7:0]  T1AC_SMR_RST    = 8'h00;
  localparam logic [7:0]  T1AC_SMR_MASK   = 8'h70;
  localparam logic [1:0]  T1AC_CSS_RST    = 2'h0;
  localparam logic [2:0]  T1AC_MODE_RST   = 3'h0;

  // ---------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    T1AC_FR_ESF = 2'b00,
    T1AC_FR_SF  = 2'b01,
    T1AC_FR_N   = 2'b10,
    T1AC_FR_DM  = 2'b11
  } t1ac_framing_t;

  localparam logic [1:0] T1AC_SEL_00    = 2'b00;
  localparam logic [1:0] T1AC_SEL_01    = 2'b01;
  localparam logic [1:0] T1AC_SEL_10    = 2'b10;
  localparam logic [1:0] T1AC_SEL_11    = 2'b11;
  localparam logic [1:0] T1AC_CSS_TXCLK = 2'b01;

  typedef enum logic [1:0] {
    T1AC_ST_IDLE  = 2'b00,
    T1AC_ST_SEND  = 2'b01,
    T1AC_ST_GUARD = 2'b10
  } t1ac_state_t;

  // ---------------------------------------------------------------------
  // Alarm pattern and timing
  // ---------------------------------------------------------------------
  localparam logic [7:0]  T1AC_PAT_COUNT  = 8'hff;
  localparam logic [3:0]  T1AC_PAT_LAST   = 4'hf;
  localparam logic [3:0]  T1AC_PAT_HALF   = 4'h8;
  localparam int unsigned T1AC_CLK_MHZ    = 200;
  localparam int unsigned T1AC_GUARD_US   = 1000000;
  localparam int unsigned T1AC_GUARD_CYC  = T1AC_GUARD_US * T1AC_CLK_MHZ;

endpackage

/* File: t1ac_sync2.sv */
// Two flip-flop synchroniser for a group of slow levels.
`timescale 1ns/100ps
module t1ac_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule

/* File: t1ac_sys_term.sv */
// System-side model that drives the transmit backplane boundary pins.
`timescale 1ns/100ps
module t1ac_sys_term (
  // Serial clock and boundary levels toward the framer
  output logic sclk_o,
  output logic frame_o,
  output logic mframe_o
);
  logic run_q;

  initial begin
    sclk_o   = 1'h0;
    frame_o  = 1'h0;
    mframe_o = 1'h0;
    run_q    = 1'h0;
  end

  // The serial clock only runs while a boundary is being marked.
  always #62.5 if (run_q) sclk_o = ~sclk_o;

  // Levels change on falling edges so that a rising edge samples them.
  task automatic mark(input logic f, input logic m);
    run_q = 1'h1;
    @(negedge sclk_o);
    frame_o  = f;
    mframe_o = m;
    @(negedge sclk_o);
    frame_o  = 1'h0;
    mframe_o = 1'h0;
    @(negedge sclk_o);
    run_q = 1'h0;
  endtask
endmodule

/* File: t1_alarm_and_tx_sync_control_tb.sv */
// Self-checking bench for the alarm and transmit sync control block.
`timescale 1ns/100ps
module t1_alarm_and_tx_sync_control_tb;
  import t1ac_pkg::*;
  localparam int unsigned GUARD = 50;
  logic        clk_i = 1'h0, rst_b_i = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [13:0] paddr = 14'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, rerr, early;
  logic        dl_slot_i = 1'h0, int_frame_i = 1'h0, int_mframe_i = 1'h0;
  logic        sclk, m_f, m_m, f_o, f_oe, mf_o, mf_oe, f_st, mf_st;
  logic        active, bit2, ybit, fs12, dl_ovr, dl_bit;
  logic        ais_u, ais_f, det_u, det_f, seen_f = 1'h0, seen_m = 1'h0;
  int          failures = 0, check_count = 0, cyc = 0, n;
  logic [7:0]  b_smr [5] = '{8'h10, 8'h10, 8'h10, 8'h70, 8'h30};
  logic [2:0]  b_mode[5] = '{3'h0, 3'h0, 3'h4, 3'h4, 3'h4};
  logic [3:0]  b_fmx [5] = '{4'ha, 4'h5, 4'h4, 4'h9, 4'ha};

  t1ac_ctrl #(.GUARD_CYCLES(GUARD)) u_t1ac_ctrl (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dl_slot_i(dl_slot_i),
    .int_frame_i(int_frame_i), .int_mframe_i(int_mframe_i),
    .tx_serial_clock_i(sclk), .tx_frame_boundary_i(f_oe ? f_o : m_f),
    .tx_frame_boundary_o(f_o), .tx_frame_boundary_oe_o(f_oe),
    .tx_multiframe_boundary_i(mf_oe ? mf_o : m_m),
    .tx_multiframe_boundary_o(mf_o), .tx_multiframe_boundary_oe_o(mf_oe),
    .tx_frame_start_o(f_st), .tx_mframe_start_o(mf_st),
    .rai_active_o(active), .rai_bit2_zero_o(bit2), .rai_ybit_zero_o(ybit),
    .rai_fs12_one_o(fs12), .dl_override_o(dl_ovr), .dl_bit_o(dl_bit),
    .tx_ais_unframed_o(ais_u), .tx_ais_framed_o(ais_f),
    .rx_ais_unframed_en_o(det_u), .rx_ais_framed_en_o(det_f));

  t1ac_sys_term u_t1ac_sys_term (.sclk_o(sclk), .frame_o(m_f), .mframe_o(m_m));

  always #2.5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (f_st === 1'h1) seen_f <= 1'h1;
    if (mf_st === 1'h1) seen_m <= 1'h1;
    if (cyc == 90000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, exp, input string what);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  task automatic apb(input logic wr, input logic [13:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_i);
    penable <= 1'h1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) begin
      failures++;
      $display("[ERR] %0t no pready", $time);
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic alarm_generation_control(input logic [7:0] v);
    apb(1'h1, T1AC_AGR_ADDR, {24'h0, v});
  endtask

  // Runs one alarm on the data link and counts the bit slots it lasts.
  task automatic burst(input logic [1:0] fmt, input int kick, stop,
                       output int cnt);
    logic [15:0] pat;
    pat = (fmt == 2'h3) ? 16'hffff : 16'hff00;
    cnt = 0;
    alarm_generation_control({2'h3, fmt, 4'h0});
    if (stop == 0) alarm_generation_control({2'h2, fmt, 4'h0});
    wt(4);
    while (active === 1'h1 && cnt < 9000) begin
      dl_slot_i <= 1'h1;
      @(posedge clk_i);
      dl_slot_i <= 1'h0;
      // Three edges let the active flag fall after the final slot.
      wt(3);
      chk1(dl_bit, pat[15 - cnt % 16], "pattern bit");
      cnt++;
      if (cnt == kick) begin
        alarm_generation_control({2'h3, fmt, 4'h0});
        alarm_generation_control({2'h2, fmt, 4'h0});
      end
      if (cnt == stop) alarm_generation_control({2'h2, fmt, 4'h0});
    end
  endtask

  initial begin
    wt(12);
    rst_b_i <= 1'h1;
    wt(2);
    apb(1'h0, T1AC_AGR_ADDR, 32'h0);
    chk32(rdata, {24'h0, T1AC_AGR_RST}, "agr reset");
    apb(1'h1, T1AC_SMR_ADDR, 32'hff);
    apb(1'h0, T1AC_SMR_ADDR, 32'h0);
    chk32(rdata, {24'h0, T1AC_SMR_MASK}, "smr reserved bits");
    apb(1'h1, 14'h7fc, 32'h1);
    chk1(rerr, 1'h1, "unmapped write");
    apb(1'h1, T1AC_STAT_ADDR, 32'h1);
    chk1(rerr, 1'h1, "status write");
    $display("%0t test registers done", $time);
    for (int k = 0; k < 4; k++) begin
      alarm_generation_control({4'h0, k[1:0], k[1:0]});
      wt(2);
      chk1(ais_u, k == 1, "ais unframed");
      chk1(ais_f, k == 3, "ais framed");
      chk1(det_u, k == 1, "detect unframed");
      chk1(det_f, k[0], "detect framed");
    end
    apb(1'h0, T1AC_AGR_ADDR, 32'h0);
    chk32(rdata, 32'h0f, "agr readback");
    $display("%0t test ais done", $time);
    alarm_generation_control(8'h50);
    wt(4);
    chk1(active, 1'h0, "enable without rule");
    for (int fr = 0; fr < 4; fr++) begin
      for (int fm = 0; fm < 4; fm++) begin
        apb(1'h1, T1AC_MODE_ADDR, fr);
        alarm_generation_control({2'h3, fm[1:0], 4'h0});
        wt(4);
        if (fm != 2) chk1(active, fm != 0, "alarm active");
        chk1(bit2, (fr == 1 || fr == 2) && fm[0], "bit2");
        chk1(ybit, fr == 3 && fm != 0, "ybit");
        chk1(fs12, fr == 1 && fm == 2, "fs12");
        chk1(dl_ovr, fr == 0 && fm[0], "data link");
        alarm_generation_control(8'h80);
        wt(GUARD + 10);
      end
    end
    $display("%0t test formats done", $time);
    apb(1'h1, T1AC_MODE_ADDR, 32'h0);
    burst(2'h1, 0, 0, n);
    chk32(n, 4080, "short alarm");
    alarm_generation_control(8'hd0);
    early = 1'h0;
    repeat (GUARD - 8) begin
      @(posedge clk_i);
      if (active === 1'h1) early = 1'h1;
    end
    chk1(early, 1'h0, "alarm inside gap");
    n = 0;
    while (active !== 1'h1 && n < 40) begin
      wt(1);
      n++;
    end
    chk1(active, 1'h1, "pending alarm");
    alarm_generation_control(8'h80);
    wt(GUARD + 10);
    burst(2'h3, 0, 0, n);
    chk32(n, 4080, "ones alarm");
    wt(GUARD + 10);
    burst(2'h1, 1600, 0, n);
    chk32(n, 5680, "restarted alarm");
    wt(GUARD + 10);
    burst(2'h1, 0, 4200, n);
    chk1(n >= 4200 && n <= 4216, 1'h1, "long alarm");
    wt(GUARD + 10);
    $display("%0t test alarm timing done", $time);
    apb(1'h1, T1AC_CSS_ADDR, {30'h0, T1AC_CSS_TXCLK});
    for (int r = 0; r < 5; r++) begin
      apb(1'h1, T1AC_MODE_ADDR, b_mode[r]);
      apb(1'h1, T1AC_SMR_ADDR, b_smr[r]);
      wt(2);
      chk1(f_oe | mf_oe, 1'h0, "pins as inputs");
      seen_f = 1'h0;
      seen_m = 1'h0;
      u_t1ac_sys_term.mark(b_fmx[r][3], b_fmx[r][2]);
      wt(4);
      chk1(seen_f, b_fmx[r][1], "frame start");
      chk1(seen_m, b_fmx[r][0], "multiframe start");
    end
    apb(1'h1, T1AC_MODE_ADDR, 32'h0);
    apb(1'h1, T1AC_SMR_ADDR, 32'h0);
    int_frame_i  <= 1'h1;
    int_mframe_i <= 1'h1;
    wt(4);
    chk1(f_oe & mf_oe, 1'h1, "pins as outputs");
    chk1(f_o & mf_o, 1'h1, "boundary outputs");
    $display("%0t test boundaries done", $time);
    end_of_test();
  end
endmodule
